// >>> bench/uesc_partner.sv
// far-side model: memory controller, home logic, link arbiters
// assumes the bench calls its tasks; outputs move after rising edges
`timescale 1ns/10ps

module uesc_partner
    import uesc_pkg::*;
(
    input  wire logic clk_i, // uncore clock
    output uesc_ev_t  ev_o,  // event levels and pulses
    output uesc_iso_t iso_o  // isochronous requests
);
    // quiet from time zero
    initial begin
        ev_o  = '0;
        iso_o = '0;
    end

    // hold one event pattern for n cycles, then go quiet
    task automatic hold(input uesc_ev_t e, input int n);
        @(posedge clk_i);
        ev_o <= e;
        repeat (n) @(posedge clk_i);
        ev_o <= '0;
    endtask

    // one isochronous request lasting one cycle
    task automatic iso(input uesc_iso_t r);
        @(posedge clk_i);
        iso_o <= r;
        @(posedge clk_i);
        iso_o <= '0;
    endtask
endmodule // uesc_partner

// >>> bench/uesc_top_tb.sv
// self-checking bench for the uncore event select and counter
// assumes the partner model drives every event input
`timescale 1ns/10ps

module uesc_top_tb;
    import uesc_pkg::*;

    logic        clk_i = 1'b0; // 250 MHz clock
    logic        rst_i = 1'b1; // sync reset
    logic        cyc   = 1'b0; // cyc and stb together
    logic        we    = 1'b0; // bus write
    logic [4:0]  adr   = '0;   // bus address
    logic [31:0] wdat  = '0;   // write data
    logic [3:0]  sel   = 4'hF; // byte enables on the bus
    logic [3:0]  bmask = 4'hF; // byte enables for the next cycle
    logic        ce    = 1'b1; // clock enable
    logic [31:0] rdat;         // captured read data
    logic [31:0] dout;         // read data port
    logic [2:0]  prio;         // priority update pulses
    logic        ack;          // bus acknowledge
    logic        irq;          // interrupt level
    uesc_ev_t    ev;           // partner events
    uesc_iso_t   iso;          // partner requests
    int          mismatches = 0;
    int          compares   = 0;
    int          cycles     = 0;

    // clock
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    uesc_partner i_far (.clk_i(clk_i), .ev_o(ev), .iso_o(iso));

    uesc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .ev_i(ev), .iso_i(iso),
        .wb_dat_o(dout), .wb_ack_o(ack), .prio_upd_o(prio), .irq_o(irq));

    // verdict and end of run
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // cut a hang short
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            conclude();
        end
    end

    // word compare
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle; held until ack is sampled high, released at that edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        // the previous ack must have been a one-cycle pulse
        chk("ack idle", 32'h0000_0000, 32'(ack));
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= bmask;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rdat = dout;
        cyc <= 1'b0;
    endtask

    // clear, select, run; apply pattern n cycles; stop and read total
    task automatic cnt(input logic [15:0] sel, input uesc_ev_t e, input int n,
                       input logic [31:0] exp);
        bus(1'b1, OFS_CTRL, 32'h0000_0002);
        bus(1'b1, OFS_EVSEL, {16'h0000, sel});
        bus(1'b1, OFS_CTRL, 32'h0000_0001);
        i_far.hold(e, n);
        bus(1'b1, OFS_CTRL, 32'h0000_0000);
        bus(1'b0, OFS_CNT, 32'h0000_0000);
        chk("event count", exp, rdat);
    endtask

    // stall pattern builder, single or multi flit
    function automatic uesc_ev_t stl(input logic mf, input logic [5:0] p,
                                     input logic [5:0] d, input logic [1:0] v);
        uesc_ev_t e;
        e     = '0;
        e.shared_adaptive_credit = v;
        if (mf) begin
            e.mf_pend = p;
            e.mf_ded  = d;
        end else begin
            e.sf_pend = p;
            e.sf_ded  = d;
        end
        return e;
    endfunction

    // partial writes, cancels and force-acks
    task automatic t_memctl();
        uesc_ev_t e;
        e         = '0;
        e.part_wr = 3'b101;
        cnt(16'h382F, e, 1, 32'h0000_0002);
        e.part_wr = 3'b111;
        cnt(16'h202F, e, 1, 32'h0000_0001);
        e.part_wr = 3'b011;
        cnt(16'h202F, e, 1, 32'h0000_0000);
        e = '0;
        for (int i = 0; i < 3; i++) begin
            e.cancel = 3'b001 << i;
            cnt({8'h01 << i, 8'h30}, e, 1, 32'h0000_0001);
            e.cancel = ~(3'b001 << i);
            cnt({8'h01 << i, 8'h30}, e, 1, 32'h0000_0000);
        end
        e.cancel = 3'b111;
        cnt(16'h0730, e, 2, 32'h0000_0006);
        e         = '0;
        e.frc_ack = 1'b1;
        cnt(16'h0433, e, 3, 32'h0000_0003);
        cnt(16'h0333, e, 3, 32'h0000_0000);
    endtask

    // one request, update pulse checked in the next cycle
    task automatic send(input uesc_iso_t r, input logic [2:0] exp);
        i_far.iso(r);
        @(negedge clk_i);
        chk("priority update", 32'(exp), 32'(prio));
    endtask

    // update pulses and their count under one mask
    task automatic t_prio(input logic [7:0] m, input logic [31:0] exp);
        uesc_iso_t r;
        bus(1'b1, OFS_CTRL, 32'h0000_0002);
        bus(1'b1, OFS_EVSEL, {16'h0000, m, 8'h31});
        bus(1'b1, OFS_CTRL, 32'h0000_0001);
        r = '{valid: 1'b1, hi_crit: 1'b1, match: 1'b1, chan: 2'd1};
        send(r, 3'b010);
        r.match = 1'b0;
        send(r, 3'b000);
        r = '{valid: 1'b1, hi_crit: 1'b0, match: 1'b1, chan: 2'd0};
        send(r, 3'b000);
        r.hi_crit = 1'b1;
        send(r, 3'b001);
        r.chan = 2'd3;
        send(r, 3'b000);
        bus(1'b1, OFS_CTRL, 32'h0000_0000);
        bus(1'b0, OFS_CNT, 32'h0000_0000);
        chk("update count", exp, rdat);
    endtask

    // link stalls: per channel, credits, whole link
    task automatic t_stall(input logic mf, input logic [7:0] evn);
        logic [5:0] b;
        for (int i = 0; i < 6; i++) begin
            b = 6'h01 << i;
            cnt({2'b00, b, evn}, stl(mf, b, 6'h00, 2'b00), 3, 3);
            cnt({2'b00, b, evn}, stl(mf, ~b, 6'h00, 2'b00), 3, 0);
        end
        cnt({8'h01, evn}, stl(mf, 6'h01, 6'h01, 2'b00), 3, 0);
        cnt({8'h01, evn}, stl(mf, 6'h01, 6'h00, 2'b01), 3, 0);
        cnt({8'h01, evn}, stl(mf, 6'h01, 6'h00, 2'b10), 3, 3);
        cnt({8'h07, evn}, stl(mf, 6'h3F, 6'h00, 2'b00), 4, 4);
        cnt({8'h38, evn}, stl(mf, 6'h07, 6'h00, 2'b00), 4, 0);
        cnt({8'h38, evn}, stl(mf, 6'h38, 6'h30, 2'b01), 4, 4);
    endtask

    // wrap interrupt: raise, mask, clear; unmapped reads
    task automatic t_irq();
        uesc_ev_t e;
        e         = '0;
        e.frc_ack = 1'b1;
        bus(1'b0, 5'h18, 32'h0000_0000);
        chk("unmapped read", 32'h0000_0000, rdat);
        // only the low byte lands; the mask byte keeps 38
        bmask = 4'h1;
        bus(1'b1, OFS_EVSEL, 32'h0000_FFFF);
        bmask = 4'hF;
        bus(1'b0, OFS_EVSEL, 32'h0000_0000);
        chk("byte-enable merge", 32'h0000_38FF, rdat);
        bus(1'b1, OFS_EVSEL, 32'h0000_0433);
        bus(1'b1, OFS_CNT, 32'hFFFF_FFFF);
        bus(1'b1, OFS_IRQ_EN, 32'h0000_0001);
        bus(1'b1, OFS_CTRL, 32'h0000_0001);
        i_far.hold(e, 1);
        repeat (3) @(negedge clk_i);
        chk("irq raised", 32'h0000_0001, 32'(irq));
        bus(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        chk("wrap status", 32'h0000_0001, rdat);
        bus(1'b1, OFS_IRQ_EN, 32'h0000_0000);
        @(negedge clk_i);
        chk("irq masked", 32'h0000_0000, 32'(irq));
        bus(1'b1, OFS_IRQ_EN, 32'h0000_0001);
        @(negedge clk_i);
        chk("irq again", 32'h0000_0001, 32'(irq));
        bus(1'b1, OFS_IRQ_CLR, 32'h0000_0001);
        @(negedge clk_i);
        chk("irq cleared", 32'h0000_0000, 32'(irq));
        bus(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        chk("status cleared", 32'h0000_0000, rdat);
    endtask

    // clock enable low freezes the counter while events arrive
    task automatic t_freeze();
        uesc_ev_t e;
        e         = '0;
        e.frc_ack = 1'b1;
        bus(1'b1, OFS_CTRL, 32'h0000_0002);
        bus(1'b1, OFS_EVSEL, 32'h0000_0433);
        bus(1'b1, OFS_CTRL, 32'h0000_0001);
        ce <= 1'b0;
        i_far.hold(e, 3);
        ce <= 1'b1;
        bus(1'b1, OFS_CTRL, 32'h0000_0000);
        bus(1'b0, OFS_CNT, 32'h0000_0000);
        chk("frozen count", 32'h0000_0000, rdat);
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, OFS_EVSEL, 32'h0000_0000);
        chk("select reset", 32'h0000_0000, rdat);
        bus(1'b0, OFS_CNT, 32'h0000_0000);
        chk("count reset", 32'h0000_0000, rdat);
        t_memctl();
        t_prio(8'h02, 32'h0000_0001);
        t_prio(8'h07, 32'h0000_0002);
        t_prio(8'h04, 32'h0000_0000);
        t_stall(1'b0, 8'h40);
        t_stall(1'b1, 8'h41);
        t_irq();
        t_freeze();
        conclude();
    end
endmodule // uesc_top_tb

// >>> rtl/uesc_pkg.sv
// package for the uncore event select and counter block
// assumes one uncore clock; all partner inputs are on that clock
package uesc_pkg;

    // event numbers
    localparam logic [7:0] EV_PART_WR  = 8'h2F; // partial line writes
    localparam logic [7:0] EV_CANCEL   = 8'h30; // dram cancels
    localparam logic [7:0] EV_PRIO_UPD = 8'h31; // priority updates
    localparam logic [7:0] EV_FRC_ACK  = 8'h33; // force-ack conflicts
    localparam logic [7:0] EV_SF_STALL = 8'h40; // single-flit stalls
    localparam logic [7:0] EV_MF_STALL = 8'h41; // multi-flit stalls

    // unit masks
    localparam logic [7:0] UM_CH0       = 8'h01;
    localparam logic [7:0] UM_CH1       = 8'h02;
    localparam logic [7:0] UM_CH2       = 8'h04;
    localparam logic [7:0] UM_ANY       = 8'h07;
    localparam logic [7:0] UM_PART_CH2  = 8'h20;
    localparam logic [7:0] UM_PART_ANY  = 8'h38;
    localparam logic [7:0] UM_FRC_LOCAL = 8'h04;
    localparam logic [7:0] UM_LINK0     = 8'h07;
    localparam logic [7:0] UM_LINK1     = 8'h38;

    // field positions
    localparam int PART_LSB  = 3;  // partial-write channel bits
    localparam int FRC_BIT   = 2;  // local-home force-ack bit
    localparam int EVNUM_LSB = 0;  // event number in select reg
    localparam int UMASK_LSB = 8;  // unit mask in select reg
    localparam int CTRL_RUN  = 0;  // counter enable
    localparam int CTRL_CLR  = 1;  // counter clear, self clearing
    localparam int IRQ_OVF   = 0;  // counter wrap status bit
    localparam int IRQ_W     = 1;  // status width

    // register byte offsets
    localparam logic [4:0] OFS_EVSEL    = 5'h00;
    localparam logic [4:0] OFS_CTRL     = 5'h04;
    localparam logic [4:0] OFS_CNT      = 5'h08;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h0C;
    localparam logic [4:0] OFS_IRQ_EN   = 5'h10;
    localparam logic [4:0] OFS_IRQ_CLR  = 5'h14;

    // reset values
    localparam logic [15:0] RST_EVSEL = 16'h0000;
    localparam logic [31:0] RST_CNT   = 32'h0000_0000;

    // event inputs from memory controller, home logic, link arbiters
    typedef struct packed {
        logic [2:0] part_wr;  // partial write pulse per channel
        logic [2:0] cancel;   // cancel pulse per channel
        logic       frc_ack;  // force-ack conflict to local home
        logic [5:0] sf_pend;  // single-flit vc holds a flit
        logic [5:0] sf_ded;   // single-flit dedicated credit
        logic [5:0] mf_pend;  // multi-flit vc holds a flit
        logic [5:0] mf_ded;   // multi-flit dedicated credit
        logic [1:0] shared_adaptive_credit;      // shared adaptive credit per link
    } uesc_ev_t;

    // isochronous request seen by the home logic
    typedef struct packed {
        logic       valid;    // request arrives this cycle
        logic       hi_crit;  // high or critical class
        logic       match;    // normal request already issued
        logic [1:0] chan;     // dram channel
    } uesc_iso_t;

endpackage

// >>> rtl/uesc_top.sv
// uncore event select and counter with wishbone register slave
// assumes partner event inputs are synchronous to clk_i
`timescale 1ns/10ps

module uesc_top
    import uesc_pkg::*;
(
    input  wire logic        clk_i,       // uncore clock
    input  wire logic        rst_i,       // sync reset
    input  wire logic        ce_i,        // freezes all state when low
    input  wire logic        wb_cyc_i,    // bus cycle
    input  wire logic        wb_stb_i,    // bus strobe
    input  wire logic        wb_we_i,     // bus write
    input  wire logic [4:0]  wb_adr_i,    // byte address
    input  wire logic [3:0]  wb_sel_i,    // byte enables
    input  wire logic [31:0] wb_dat_i,    // write data
    input  wire uesc_ev_t    ev_i,        // partner events
    input  wire uesc_iso_t   iso_i,       // isochronous requests
    output logic      [31:0] wb_dat_o,    // read data
    output logic             wb_ack_o,    // bus acknowledge
    output logic      [2:0]  prio_upd_o,  // priority update per channel
    output logic             irq_o        // level interrupt
);

    // three-bit population count
    function automatic logic [1:0] n3(input logic [2:0] v);
        n3 = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
    endfunction

    // a vc stalls when it has a flit but no credit of either kind
    function automatic logic [5:0] stall_vec(input logic [5:0] pend,
                                             input logic [5:0] ded,
                                             input logic [1:0] shared_adaptive_credit);
        stall_vec = pend & ~ded & ~{{3{shared_adaptive_credit[1]}}, {3{shared_adaptive_credit[0]}}};
    endfunction

    // byte-enable merge of a write into a word
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        wmerge = r;
    endfunction

    logic [15:0]      evsel_reg;   // event number and unit mask
    logic             run_reg;     // counter enable
    logic [31:0]      cnt_reg;     // event counter
    logic [IRQ_W-1:0] stat_reg;    // sticky status
    logic [IRQ_W-1:0] en_reg;      // interrupt enables
    logic             irq_reg;     // interrupt level
    logic             ack_reg;     // bus ack
    logic [31:0]      rdat_reg;    // bus read data
    logic [2:0]       prio_reg;    // priority update pulses

    logic [7:0]       ev_num;      // selected event number
    logic [7:0]       umask;       // selected unit mask
    logic             take;        // bus request taken this edge
    logic             wr;          // write taken this edge
    logic [31:0]      evsel_next;  // merged select write
    logic [31:0]      cnt_next;    // merged counter write
    logic [31:0]      ctrl_next;   // merged control write
    logic [31:0]      en_next;     // merged enable write
    logic             cnt_clr;     // clear request
    logic             cnt_load;    // counter write
    logic [5:0]       sf_stall;    // single-flit stall vector
    logic [5:0]       mf_stall;    // multi-flit stall vector
    logic [1:0]       inc;         // increment this cycle
    logic [32:0]      cnt_sum;     // counter plus increment
    logic [IRQ_W-1:0] stat_set;    // status events
    logic [IRQ_W-1:0] stat_clr;    // status clears

    assign ev_num = evsel_reg[EVNUM_LSB +: 8];
    assign umask  = evsel_reg[UMASK_LSB +: 8];

    // bus decode; a request is taken once, ack follows next edge
    assign take = ce_i & wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr   = take & wb_we_i;

    assign evsel_next = wmerge({16'h0000, evsel_reg}, wb_dat_i, wb_sel_i);
    assign cnt_next   = wmerge(cnt_reg, wb_dat_i, wb_sel_i);
    assign ctrl_next  = wmerge({31'h0000_0000, run_reg}, wb_dat_i, wb_sel_i);
    assign en_next    = wmerge({{(32-IRQ_W){1'b0}}, en_reg}, wb_dat_i,
                               wb_sel_i);

    assign cnt_clr  = wr && wb_adr_i == OFS_CTRL && ctrl_next[CTRL_CLR];
    assign cnt_load = wr && wb_adr_i == OFS_CNT;

    // stall vectors ignore arbitration winners on purpose
    assign sf_stall = stall_vec(ev_i.sf_pend, ev_i.sf_ded, ev_i.shared_adaptive_credit);
    assign mf_stall = stall_vec(ev_i.mf_pend, ev_i.mf_ded, ev_i.shared_adaptive_credit);

    // event selection
    always_comb begin
        inc = 2'd0;
        case (ev_num)
            // per-occurrence events add selected occurrences
            EV_PART_WR: begin
                inc = n3(umask[PART_LSB +: 3] & ev_i.part_wr);
            end
            EV_CANCEL: begin
                inc = n3(umask[2:0] & ev_i.cancel);
            end
            EV_PRIO_UPD: begin
                inc = n3(umask[2:0] & prio_reg);
            end
            EV_FRC_ACK: begin
                inc = 2'(umask[FRC_BIT] & ev_i.frc_ack);
            end
            // cycle events count one if any selected vc stalls
            EV_SF_STALL: begin
                inc = 2'(|(umask[5:0] & sf_stall));
            end
            EV_MF_STALL: begin
                inc = 2'(|(umask[5:0] & mf_stall));
            end
            // unknown event numbers count nothing
            default: begin
                inc = 2'd0;
            end
        endcase
    end

    assign cnt_sum = {1'b0, cnt_reg} + 33'(inc);

    // priority update towards the memory controller
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prio_reg <= 3'b000;
        end else if (ce_i) begin
            prio_reg <= 3'b000;
            // channel 3 does not exist, so no update
            if (iso_i.valid && iso_i.hi_crit && iso_i.match &&
                iso_i.chan != 2'd3) begin
                prio_reg <= 3'(3'b001 << iso_i.chan);
            end
        end
    end

    // event select register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evsel_reg <= RST_EVSEL;
        end else if (ce_i && wr && wb_adr_i == OFS_EVSEL) begin
            evsel_reg <= evsel_next[15:0];
        end
    end

    // control register; clear bit is a strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_reg <= 1'b0;
        end else if (ce_i && wr && wb_adr_i == OFS_CTRL) begin
            run_reg <= ctrl_next[CTRL_RUN];
        end
    end

    // counter; clear beats load beats counting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= RST_CNT;
        end else if (ce_i) begin
            if (cnt_clr) begin
                cnt_reg <= RST_CNT;
            end else if (cnt_load) begin
                cnt_reg <= cnt_next;
            end else if (run_reg) begin
                cnt_reg <= cnt_sum[31:0];
            end
        end
    end

    // status: counter wrap only when the counting path is used
    always_comb begin
        stat_set = '0;
        stat_set[IRQ_OVF] = run_reg & cnt_sum[32] & ~cnt_clr & ~cnt_load;
        stat_clr = '0;
        if (wr && wb_adr_i == OFS_IRQ_CLR && wb_sel_i[0]) begin
            stat_clr = wb_dat_i[IRQ_W-1:0];
        end
    end

    // sticky status; a set in the clear cycle survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_reg <= '0;
        end else if (ce_i) begin
            stat_reg <= (stat_reg & ~stat_clr) | stat_set;
        end
    end

    // interrupt enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_reg <= '0;
        end else if (ce_i && wr && wb_adr_i == OFS_IRQ_EN) begin
            en_reg <= en_next[IRQ_W-1:0];
        end
    end

    // interrupt level, one cycle behind status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_reg <= 1'b0;
        end else if (ce_i) begin
            irq_reg <= |(stat_reg & en_reg);
        end
    end

    // bus answer: ack one cycle after take, read data with it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_reg <= take;
            if (take) begin
                unique case (wb_adr_i)
                    OFS_EVSEL:    rdat_reg <= {16'h0000, evsel_reg};
                    OFS_CTRL:     rdat_reg <= {31'h0000_0000, run_reg};
                    OFS_CNT:      rdat_reg <= cnt_reg;
                    OFS_IRQ_STAT: rdat_reg <= {{(32-IRQ_W){1'b0}}, stat_reg};
                    OFS_IRQ_EN:   rdat_reg <= {{(32-IRQ_W){1'b0}}, en_reg};
                    // clear register and holes read zero
                    default:      rdat_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_dat_o   = rdat_reg;
    assign wb_ack_o   = ack_reg;
    assign prio_upd_o = prio_reg;
    assign irq_o      = irq_reg;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_part_any_sum: assert property (
        ev_num == EV_PART_WR && umask == UM_PART_ANY
        |-> inc == n3(ev_i.part_wr))
        else $error("partial write any-channel count wrong");

    a_part_ch2_only: assert property (
        ev_num == EV_PART_WR && umask == UM_PART_CH2
        |-> inc == 2'(ev_i.part_wr[2]))
        else $error("partial write channel 2 count wrong");

    a_cancel_ch1: assert property (
        ev_num == EV_CANCEL && umask == UM_CH1
        |-> inc == 2'(ev_i.cancel[1]))
        else $error("cancel channel 1 count wrong");

    a_prio_any: assert property (
        ev_num == EV_PRIO_UPD && umask == UM_ANY
        |-> inc == n3(prio_upd_o))
        else $error("priority update count wrong");

    a_prio_issue: assert property (
        ce_i && iso_i.valid && iso_i.hi_crit && iso_i.match
        && iso_i.chan == 2'd1
        |=> prio_upd_o == 3'b010)
        else $error("priority update not issued");

    a_prio_quiet: assert property (
        ce_i && !(iso_i.valid && iso_i.hi_crit && iso_i.match)
        |=> prio_upd_o == 3'b000)
        else $error("spurious priority update");

    a_frc_local: assert property (
        ev_num == EV_FRC_ACK && umask == UM_FRC_LOCAL
        |-> inc == 2'(ev_i.frc_ack))
        else $error("force-ack count wrong");

    a_sf_home_l0: assert property (
        ev_num == EV_SF_STALL && umask == UM_CH0
        |-> inc == 2'(ev_i.sf_pend[0] & ~ev_i.sf_ded[0] & ~ev_i.shared_adaptive_credit[0]))
        else $error("home link 0 stall wrong");

    a_sf_link1: assert property (
        ev_num == EV_SF_STALL && umask == UM_LINK1
        |-> inc == 2'(|(ev_i.sf_pend[5:3] & ~ev_i.sf_ded[5:3])
                      & ~ev_i.shared_adaptive_credit[1]))
        else $error("link 1 single-flit stall wrong");

    a_mf_link0: assert property (
        ev_num == EV_MF_STALL && umask == UM_LINK0 && ev_i.shared_adaptive_credit[0]
        |-> inc == 2'd0)
        else $error("stall counted with shared credit");

    a_mf_link1: assert property (
        ev_num == EV_MF_STALL && umask == UM_LINK1
        |-> inc == 2'(|(ev_i.mf_pend[5:3] & ~ev_i.mf_ded[5:3])
                      & ~ev_i.shared_adaptive_credit[1]))
        else $error("link 1 multi-flit stall wrong");

    a_cnt_step: assert property (
        ce_i && run_reg && !cnt_clr && !cnt_load
        |=> cnt_reg == $past(cnt_reg) + 32'($past(inc)))
        else $error("counter did not advance by increment");

    a_ack_pulse: assert property (
        take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse");

    a_irq_level: assert property (
        ce_i && |(stat_reg & en_reg) |=> irq_o)
        else $error("interrupt missed");

    c_part_sum: cover property (
        ev_num == EV_PART_WR && inc == 2'd3);
    c_sf_stall: cover property (
        ev_num == EV_SF_STALL && inc == 2'd1 ##1 inc == 2'd1);
    c_prio_count: cover property (
        ev_num == EV_PRIO_UPD && run_reg && inc != 2'd0);
    c_wrap_irq: cover property (
        stat_set[IRQ_OVF] ##[1:3] irq_o);

endmodule // uesc_top
